// ===== host_model.sv
// Host-side model: drives the flag clears and sync search, captures the holding register on each rising ready flag
`default_nettype none

module host_model
    import sync_rx_pkg::*;
(
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic                           sfc_req,
    input  wire logic                           rdc_req,
    input  wire logic                           hunt_req,
    input  wire logic                           rx_ready_flag,
    input  wire logic [sync_rx_pkg::HOLD_W-1:0] rx_holding_out,
    output logic                                status_flag_clear_n,
    output logic                                rx_ready_clear_n,
    output logic                                sync_search_ctrl,
    output logic                                got_char,
    output logic      [sync_rx_pkg::HOLD_W-1:0] got_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ready_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            status_flag_clear_n <= 1'b1;
            rx_ready_clear_n    <= 1'b1;
            sync_search_ctrl    <= 1'b0;
        end
        else
        begin
            status_flag_clear_n <= ~sfc_req;
            rx_ready_clear_n    <= ~rdc_req;
            // Low to high starts the hunt, high to low drops sync
            sync_search_ctrl    <= hunt_req;
        end
    end

    // Take the holding register once per rising ready flag
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ready_q  <= 1'b0;
            got_char <= 1'b0;
            got_data <= 9'h000;
        end
        else
        begin
            ready_q  <= rx_ready_flag;
            got_char <= rx_ready_flag & ~ready_q;
            if (rx_ready_flag & ~ready_q)
                got_data <= rx_holding_out;
        end
    end
endmodule

`default_nettype wire

// ===== pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module pin_sync3
    import sync_rx_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [PIN_W-1:0] pin_in,
    output logic      [PIN_W-1:0] level_out
);

    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] level_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= PIN_RESET;
            s2_q <= PIN_RESET;
            s3_q <= PIN_RESET;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level is taken only once stages two and three agree
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            level_q <= PIN_RESET;
        else
            level_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);
    end

    assign level_out = level_q;

endmodule

`default_nettype wire

// ===== sync_char_receiver_flags.sv
// Synchronous character receiver with holding register, parity and status flags
//
// Summary of operation
// [RL1] Nine holding outputs, parity on top line
// [RL2] Short characters right-justified, upper lines low
// [RL3] Parity off, else even or odd select
// [RL4] Parity bit checked after last data bit
// [RL5] Low status clear resets parity, overrun flags
// [RL6] Low ready clear resets data-received flag
// [RL7] Ready flag rises after character transfer
// [RL8] First sync match raises match, not ready
// [RL9] Transfer and ready update at last bit
// [RL10] Holding outputs driven only when enabled
// [RL11] Select and clear inputs gated by disable
// [RL12] Two-bit code selects five to eight bits
// [RL13] Master reset idles, holding ones, flags cleared
// [RL14] Overrun when ready still set at transfer
// [RL15] Sync search rising hunts, falling drops sync
// [RL16] Clears act on level, clear holds flag
`default_nettype none

module sync_char_receiver_flags
(
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         rx_bit_clock,
    input  wire logic                         rx_serial_in,
    input  wire logic                         chip_disable,
    input  wire logic                         parity_off,
    input  wire logic                         even_parity_select,
    input  wire logic [sync_rx_pkg::LEN_W-1:0] char_length_select,
    input  wire logic                         status_flag_clear_n,
    input  wire logic                         rx_ready_clear_n,
    input  wire logic                         master_reset,
    input  wire logic                         sync_search_ctrl,
    input  wire logic [sync_rx_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [sync_rx_pkg::BUS_W-1:0] bus_wdata,
    input  wire logic                         bus_wr,
    input  wire logic                         bus_rd,
    output logic      [sync_rx_pkg::BUS_W-1:0] bus_rdata,
    output logic      [sync_rx_pkg::HOLD_W-1:0] rx_holding_out,
    output logic                              rx_holding_oe,
    output logic                              rx_ready_flag,
    output logic                              parity_error_flag,
    output logic                              overrun_flag,
    output logic                              sync_match_flag,
    output logic                              flags_oe,
    output logic                              irq
);

    import sync_rx_pkg::*;
    // Length in bits for a select code
    function automatic logic [3:0] char_bits(input logic [1:0] code);
        char_bits = CHAR_MIN_BITS + {2'b00, code}; // RL12
    endfunction
    // Mask of the data lines in use for a length
    function automatic logic [7:0] data_mask(input logic [3:0] nbits);
        data_mask = 8'hff >> (DATA_BITS - nbits);
    endfunction

    logic [PIN_W-1:0]  pins_raw;
    logic [PIN_W-1:0]  pins;
    logic              clk_lvl;
    logic              cd_lvl;
    logic              mr_lvl;
    logic              ss_lvl;
    logic              clk_prev_q;
    logic              ss_prev_q;
    logic              bit_tick;
    logic              ss_rise;
    logic              ss_fall;
    logic [1:0]        len_q;
    logic              par_off_q;
    logic              even_q;
    logic              sfc_act;
    logic              rdc_act;
    rx_state_e         state_q;
    rx_state_e         state_d;
    logic [8:0]        shreg_q;
    logic [8:0]        shreg_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [3:0]        len_bits;
    logic [3:0]        frame_bits;
    logic [8:0]        frame;
    logic [7:0]        char_data;
    logic              par_bit;
    logic              par_err;
    logic              cnt_last;
    logic              hunt_hit;
    logic              char_done;
    logic              idle_tick;
    logic              is_match;
    logic [8:0]        holding_q;
    logic [7:0]        match_q;
    logic              ready_q;
    logic              pe_q;
    logic              ovr_q;
    logic              sync_match_flag_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] mask_q;
    logic [STAT_W-1:0] events;
    logic [BUS_W-1:0]  rdata_q;

    // Every pin except the register port is brought into the sys_clk domain
    assign pins_raw = {char_length_select, sync_search_ctrl, master_reset, rx_ready_clear_n,
                       status_flag_clear_n, even_parity_select, parity_off, chip_disable,
                       rx_serial_in, rx_bit_clock};

    pin_sync3 u_pin_sync (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_in    (pins_raw),
        .level_out (pins)
    );

    assign clk_lvl = pins[PIN_RXCLK];
    assign cd_lvl  = pins[PIN_CD];
    assign mr_lvl  = pins[PIN_MR];
    assign ss_lvl  = pins[PIN_SS];
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_prev_q <= 1'b0;
            ss_prev_q  <= 1'b0;
        end
        else
        begin
            clk_prev_q <= clk_lvl;
            ss_prev_q  <= ss_lvl;
        end
    end

    // Bits are taken on the falling edge of the bit clock
    assign bit_tick = clk_prev_q & ~clk_lvl;
    assign ss_rise  = ~ss_prev_q & ss_lvl;
    assign ss_fall  = ss_prev_q & ~ss_lvl;

    // Select inputs only follow the pins while the chip is enabled
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            len_q     <= LEN_RESET;
            par_off_q <= 1'b1;
            even_q    <= 1'b0;
        end
        else if (!cd_lvl)
        begin
            len_q     <= pins[PIN_LEN +: LEN_W];
            par_off_q <= pins[PIN_POFF]; // RL3 RL11
            even_q    <= pins[PIN_EVEN]; // RL11
        end
    end
    assign sfc_act = ~cd_lvl & ~pins[PIN_SFC_N]; // RL11
    assign rdc_act = ~cd_lvl & ~pins[PIN_RDC_N]; // RL11
    // Frame view of the receiver shift register after the incoming bit
    assign shreg_d    = {pins[PIN_RXDAT], shreg_q[8:1]};
    assign len_bits   = char_bits(len_q);
    assign frame_bits = len_bits + {3'b000, ~par_off_q}; // RL4
    assign frame      = shreg_d >> (HOLD_BITS - frame_bits);
    assign char_data  = frame[7:0] & data_mask(len_bits); // RL2
    assign par_bit    = ~par_off_q & frame[len_bits]; // RL4
    assign par_err    = ~par_off_q & ((^{char_data, par_bit}) == even_q); // RL3 RL4
    assign is_match   = (char_data == (match_q & data_mask(len_bits)));
    assign cnt_last   = (cnt_q == frame_bits - 4'h1);
    assign idle_tick = (state_q == ST_IDLE) & bit_tick;
    assign hunt_hit  = (state_q == ST_HUNT) & bit_tick & is_match; // RL8
    assign char_done = (state_q == ST_LOCKED) & bit_tick & cnt_last; // RL9

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            shreg_q <= SHIFT_RESET;
        else if (mr_lvl)
            shreg_q <= SHIFT_RESET; // RL13
        else if (bit_tick)
            shreg_q <= shreg_d;
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (ss_rise)
                    state_d = ST_HUNT; // RL15
            ST_HUNT:
                if (ss_fall)
                    state_d = ST_IDLE; // RL15
                else if (hunt_hit)
                    state_d = ST_LOCKED;
            ST_LOCKED:
                if (ss_fall)
                    state_d = ST_IDLE; // RL15
            default:
                state_d = ST_IDLE;
        endcase
        if (mr_lvl)
            state_d = ST_IDLE; // RL13
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Bit position within a locked character
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= CNT_RESET;
        else if (mr_lvl || state_q != ST_LOCKED)
            cnt_q <= CNT_RESET;
        else if (bit_tick)
            cnt_q <= cnt_last ? CNT_RESET : cnt_q + 4'h1;
    end

    // Holding register: transparent while idle, loaded per character once locked
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            holding_q <= HOLD_RESET;
        else if (mr_lvl)
            holding_q <= HOLD_RESET; // RL13
        else if (idle_tick || hunt_hit || char_done)
            holding_q <= {par_bit, char_data}; // RL1 RL2 RL9
    end

    // Clear inputs win over a transfer while held low
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ready_q <= 1'b0;
        else if (mr_lvl || rdc_act)
            ready_q <= 1'b0; // RL6 RL13 RL16
        else if (char_done)
            ready_q <= 1'b1; // RL7 RL9
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pe_q  <= 1'b0;
            ovr_q <= 1'b0;
        end
        else if (mr_lvl || sfc_act)
        begin
            pe_q  <= 1'b0; // RL5 RL13 RL16
            ovr_q <= 1'b0; // RL5 RL16
        end
        else if (char_done)
        begin
            pe_q  <= par_err; // RL4
            ovr_q <= ovr_q | (ready_q & ~rdc_act); // RL14
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            sync_match_flag_q <= 1'b0;
        else if (mr_lvl)
            sync_match_flag_q <= 1'b0; // RL13
        else if (hunt_hit)
            sync_match_flag_q <= 1'b1; // RL8
        else if (char_done)
            sync_match_flag_q <= is_match;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            match_q <= MATCH_RESET;
        else if (mr_lvl)
            match_q <= MATCH_RESET; // RL13
        else if (bus_wr && bus_addr == REG_MATCH)
            match_q <= bus_wdata[7:0];
    end

    // Interrupt status: events set, a status read clears, set wins
    assign events[ST_READY]   = char_done & ~rdc_act;
    assign events[ST_MATCH]   = hunt_hit | (char_done & is_match);
    assign events[ST_PARITY]  = char_done & par_err & ~sfc_act;
    assign events[ST_OVERRUN] = char_done & ready_q & ~rdc_act & ~sfc_act;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stat_q <= STAT_RESET;
        else if (bus_rd && bus_addr == REG_STATUS)
            stat_q <= events;
        else
            stat_q <= stat_q | events;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mask_q <= STAT_RESET;
        else if (bus_wr && bus_addr == REG_MASK)
            mask_q <= bus_wdata[STAT_W-1:0];
    end

    // Read data stands for one cycle only; unmapped reads as zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdata_q <= BUS_ZERO;
        else if (bus_rd)
            unique case (bus_addr)
                REG_STATUS:  rdata_q <= {28'h000_0000, stat_q};
                REG_MASK:    rdata_q <= {28'h000_0000, mask_q};
                REG_HOLDING: rdata_q <= {23'h00_0000, holding_q};
                REG_MATCH:   rdata_q <= {24'h00_0000, match_q};
                default:     rdata_q <= BUS_ZERO;
            endcase
        else
            rdata_q <= BUS_ZERO;
    end

    assign bus_rdata         = rdata_q;
    assign rx_holding_out    = holding_q; // RL1
    assign rx_holding_oe     = ~cd_lvl; // RL10
    assign flags_oe          = ~cd_lvl;
    assign rx_ready_flag     = ready_q;
    assign parity_error_flag = pe_q;
    assign overrun_flag      = ovr_q;
    assign sync_match_flag   = sync_match_flag_q;
    assign irq               = |(stat_q & mask_q);

    a_holding_drive: assert property (@(posedge sys_clk) disable iff (rst) // RL10
        rx_holding_oe == !pins[PIN_CD])
        else $error("holding outputs driven while disabled");
    a_ready_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL6
        (!pins[PIN_RDC_N] && !pins[PIN_CD]) |=> !rx_ready_flag)
        else $error("ready flag not cleared");
    a_status_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        (!pins[PIN_SFC_N] && !pins[PIN_CD]) |=> (!parity_error_flag && !overrun_flag))
        else $error("status flags not cleared");
    a_ready_set: assert property (@(posedge sys_clk) disable iff (rst) // RL7
        (char_done && !rdc_act && !mr_lvl) |=> (rx_ready_flag && rx_holding_out == $past({par_bit, char_data})))
        else $error("ready or holding not updated at transfer");
    a_first_sync: assert property (@(posedge sys_clk) disable iff (rst) // RL8
        (hunt_hit && !ready_q && !mr_lvl) |=> (sync_match_flag && !rx_ready_flag && state_q == ST_LOCKED))
        else $error("first sync character mishandled");
    a_overrun_set: assert property (@(posedge sys_clk) disable iff (rst) // RL14
        (char_done && ready_q && !rdc_act && !sfc_act && !mr_lvl) |=> overrun_flag)
        else $error("overrun not flagged");
    a_right_justify: assert property (@(posedge sys_clk) disable iff (rst) // RL2
        (char_done && !mr_lvl) |=> ((rx_holding_out[7:0] & ~$past(data_mask(len_bits))) == 8'h00))
        else $error("unused data lines not low");
    a_parity_none: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        (char_done && par_off_q && !mr_lvl) |=> (!rx_holding_out[8] && !$rose(parity_error_flag)))
        else $error("parity acted on while off");
    a_master_reset: assert property (@(posedge sys_clk) disable iff (rst) // RL13
        mr_lvl |=> (rx_holding_out == HOLD_RESET && !rx_ready_flag && !sync_match_flag && state_q == ST_IDLE))
        else $error("master reset incomplete");
    a_sync_drop: assert property (@(posedge sys_clk) disable iff (rst) // RL15
        ss_fall |=> state_q == ST_IDLE)
        else $error("sync not dropped");

endmodule
`default_nettype wire

// ===== sync_char_receiver_flags_tb.sv
// Testbench for the synchronous character receiver
`default_nettype none

module sync_char_receiver_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sync_rx_pkg::*;

    typedef struct packed { logic [31:0] val; logic [31:0] msk; } exp_s;
    localparam logic [7:0] SYNC_CHAR = 8'h16;

    logic                sys_clk, rst, rx_bit_clock, rx_serial_in, chip_disable, master_reset;
    logic                parity_off, even_parity_select, bus_wr, bus_rd, rd_seen;
    logic [LEN_W-1:0]    char_length_select;
    logic [ADDR_W-1:0]   bus_addr;
    logic [BUS_W-1:0]    bus_wdata, bus_rdata;
    logic [HOLD_W-1:0]   rx_holding_out, got_data;
    logic                rx_holding_oe, rx_ready_flag, parity_error_flag, overrun_flag, sync_match_flag;
    logic                flags_oe, irq, status_flag_clear_n, rx_ready_clear_n, sync_search_ctrl;
    logic                sfc_req, rdc_req, hunt_req, got_char;
    int                  num_errors, checks, cycles, seed;
    exp_s                bus_q[$];
    exp_s                char_q[$];
    exp_s                e;

    sync_char_receiver_flags u_dut (
        .sys_clk, .rst, .rx_bit_clock, .rx_serial_in, .chip_disable, .parity_off, .even_parity_select,
        .char_length_select, .status_flag_clear_n, .rx_ready_clear_n, .master_reset, .sync_search_ctrl,
        .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .rx_holding_out, .rx_holding_oe,
        .rx_ready_flag, .parity_error_flag, .overrun_flag, .sync_match_flag, .flags_oe, .irq
    );

    host_model u_host (
        .sys_clk, .rst, .sfc_req, .rdc_req, .hunt_req, .rx_ready_flag, .rx_holding_out,
        .status_flag_clear_n, .rx_ready_clear_n, .sync_search_ctrl, .got_char, .got_data
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Flags as {ready, parity, overrun, match}
    task automatic chk_flags(input logic [3:0] exp, input logic [3:0] msk);
        @(negedge sys_clk);
        cmp({28'h0, {rx_ready_flag, parity_error_flag, overrun_flag, sync_match_flag} & msk}, {28'h0, exp});
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic bus_read(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        bus_q.push_back('{exp, msk});
        @(posedge sys_clk);
        bus_rd   <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Bit clock stands high between frames, data changes half a bit before the falling edge
    task automatic send_char(input logic [8:0] f, input int n);
        for (int i = 0; i < n; i++)
        begin
            rx_serial_in <= f[i];
            rx_bit_clock <= 1'b1;
            wait_cyc(10);
            rx_bit_clock <= 1'b0;
            wait_cyc(10);
        end
        rx_bit_clock <= 1'b1;
        rx_serial_in <= ~f[n-1];
        wait_cyc(10);
    endtask

    function automatic logic par(input logic [8:0] d, input logic ev);
        return ev ? ^d : ~(^d);
    endfunction

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    always @(posedge sys_clk)
    begin
        rd_seen <= bus_rd;
        if (rd_seen === 1'b1)
        begin
            if (bus_q.size() == 0)
                num_errors++;
            else
            begin
                e = bus_q.pop_front();
                cmp(bus_rdata & e.msk, e.val);
            end
        end
        if (got_char === 1'b1)
        begin
            if (char_q.size() == 0)
                num_errors++;
            else
            begin
                e = char_q.pop_front();
                cmp({23'h0, got_data} & e.msk, e.val);
            end
        end
    end

    initial
    begin : main
        logic [8:0] mask;
        logic [8:0] d;
        logic       p;
        int         nb;
        {num_errors, checks, cycles} = '0;
        seed = 28;
        {rst, rx_bit_clock, parity_off} = 3'b111;
        {rx_serial_in, chip_disable, even_parity_select, master_reset, bus_wr, bus_rd} = '0;
        {sfc_req, rdc_req, hunt_req} = '0;
        char_length_select = 2'h3;
        bus_addr = 4'h0;
        bus_wdata = 32'h0000_0000;
        wait_cyc(5);
        rst <= 1'b0;
        wait_cyc(8);
        bus_write(REG_MASK, 32'h0000_0001);
        bus_read(REG_MASK, 32'h0000_0001, 32'h0000_000f);
        bus_read(4'h2, 32'h0000_0000, 32'hffff_ffff);
        $display("test register port done");
        for (int len = 0; len < 4; len++)
        begin
            nb = len + 5;
            mask = 9'((1 << nb) - 1);
            hunt_req <= 1'b0;
            parity_off <= 1'b1;
            char_length_select <= 2'(len);
            even_parity_select <= len[0];
            wait_cyc(8);
            master_reset <= 1'b1;
            wait_cyc(8);
            master_reset <= 1'b0;
            wait_cyc(8);
            chk_flags(4'h0, 4'hf);
            cmp({23'h0, rx_holding_out}, 32'h0000_01ff);
            wait_cyc(1);
            bus_read(REG_MATCH, 32'h0000_0000, 32'h0000_00ff);
            bus_read(REG_STATUS, (len == 0) ? 32'h0000_0000 : 32'h0000_000d, 32'h0000_000d);
            bus_write(REG_MATCH, {24'h0, SYNC_CHAR & mask[7:0]});
            hunt_req <= 1'b1;
            wait_cyc(8);
            send_char({1'b0, SYNC_CHAR} & mask, nb);
            chk_flags(4'h1, 4'hf);
            wait_cyc(1);
            parity_off <= 1'b0;
            wait_cyc(8);
            d = 9'($random(seed)) & mask;
            p = par(d, len[0]);
            char_q.push_back('{{23'h0, p, d[7:0]}, 32'h0000_01ff});
            send_char(d | (9'(p) << nb), nb + 1);
            chk_flags(4'h8, 4'he);
            cmp({31'h0, irq}, 32'h0000_0001);
            wait_cyc(1);
            bus_read(REG_STATUS, 32'h0000_0001, 32'h0000_000d);
            bus_read(REG_HOLDING, {23'h0, p, d[7:0]}, 32'h0000_01ff);
            @(negedge sys_clk);
            cmp({31'h0, irq}, 32'h0000_0000);
            wait_cyc(1);
            d = 9'($random(seed)) & mask;
            send_char(d | (9'(~par(d, len[0])) << nb), nb + 1);
            chk_flags(4'he, 4'he);
            wait_cyc(1);
            sfc_req <= 1'b1;
            wait_cyc(8);
            chk_flags(4'h8, 4'he);
            wait_cyc(1);
            send_char(d | (9'(~par(d, len[0])) << nb), nb + 1);
            chk_flags(4'h8, 4'he);
            wait_cyc(1);
            sfc_req <= 1'b0;
            rdc_req <= 1'b1;
            wait_cyc(8);
            chk_flags(4'h0, 4'he);
            wait_cyc(1);
            rdc_req <= 1'b0;
            parity_off <= 1'b1;
            wait_cyc(8);
            d = 9'($random(seed)) & mask;
            char_q.push_back('{{23'h0, 1'b0, d[7:0]}, 32'h0000_00ff});
            send_char(d, nb);
            chk_flags(4'h8, 4'he);
            $display("test length code %0d done", len);
            wait_cyc(1);
        end
        chip_disable <= 1'b1;
        rdc_req <= 1'b1;
        wait_cyc(8);
        chk_flags(4'h8, 4'h8);
        cmp({30'h0, rx_holding_oe, flags_oe}, 32'h0000_0000);
        wait_cyc(1);
        chip_disable <= 1'b0;
        wait_cyc(8);
        chk_flags(4'h0, 4'h8);
        cmp({30'h0, rx_holding_oe, flags_oe}, 32'h0000_0003);
        wait_cyc(1);
        rdc_req <= 1'b0;
        wait_cyc(4);
        $display("test chip disable done");
        hunt_req <= 1'b0;
        wait_cyc(8);
        d = 9'($random(seed)) & 9'h0ff;
        send_char(d, 8);
        cmp({23'h0, rx_holding_out}, {23'h0, d});
        $display("test sync drop done");
        give_verdict();
    end
endmodule

`default_nettype wire

// ===== sync_rx_pkg.sv
// Constants, register map and state encoding for the synchronous character receiver
`default_nettype none

package sync_rx_pkg;

    // Character and holding register geometry
    localparam int unsigned HOLD_W        = 9;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned LEN_W         = 2;
    localparam int unsigned CNT_W         = 4;
    localparam logic [3:0]  CHAR_MIN_BITS = 4'h5;
    localparam logic [3:0]  HOLD_BITS     = 4'h9;
    localparam logic [3:0]  DATA_BITS     = 4'h8;

    // Values taken on reset or master reset
    localparam logic [8:0]  HOLD_RESET    = 9'h1ff;
    localparam logic [7:0]  MATCH_RESET   = 8'h00;
    localparam logic [8:0]  SHIFT_RESET   = 9'h000;
    localparam logic [3:0]  CNT_RESET     = 4'h0;
    localparam logic [1:0]  LEN_RESET     = 2'h3;

    // Register port
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned BUS_W         = 32;
    localparam logic [3:0]  REG_STATUS    = 4'h0;
    localparam logic [3:0]  REG_MASK      = 4'h4;
    localparam logic [3:0]  REG_HOLDING   = 4'h8;
    localparam logic [3:0]  REG_MATCH     = 4'hc;
    localparam logic [31:0] BUS_ZERO      = 32'h0000_0000;

    // Interrupt status bit positions
    localparam int unsigned STAT_W        = 4;
    localparam int unsigned ST_READY      = 0;
    localparam int unsigned ST_MATCH      = 1;
    localparam int unsigned ST_PARITY     = 2;
    localparam int unsigned ST_OVERRUN    = 3;
    localparam logic [3:0]  STAT_RESET    = 4'h0;

    // Pin synchroniser vector layout
    localparam int unsigned PIN_W         = 11;
    localparam int unsigned PIN_RXCLK     = 0;
    localparam int unsigned PIN_RXDAT     = 1;
    localparam int unsigned PIN_CD        = 2;
    localparam int unsigned PIN_POFF      = 3;
    localparam int unsigned PIN_EVEN      = 4;
    localparam int unsigned PIN_SFC_N     = 5;
    localparam int unsigned PIN_RDC_N     = 6;
    localparam int unsigned PIN_MR        = 7;
    localparam int unsigned PIN_SS        = 8;
    localparam int unsigned PIN_LEN       = 9;
    // Clears idle high, chip disabled, length 8
    localparam logic [10:0] PIN_RESET     = 11'h664;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_HUNT   = 2'b01,
        ST_LOCKED = 2'b11
    } rx_state_e;

endpackage

`default_nettype wire
